// [hdl/mrlh_map.svh]
// constants for the mode, reset and limp home controller
// assumes inclusion by the package; the design modules use its macros without including it
`ifndef MRLH_MAP_SVH
`define MRLH_MAP_SVH
`define MRLH_CLK_MHZ        200
`define MRLH_UVR_DLY_NS     1000
`define MRLH_NCH            8
`define MRLH_LH_CH_A        4
`define MRLH_LH_CH_B        5
`define MRLH_CH_OFF         8'h00
`define MRLH_CTRL_DEF       8'h00
`define MRLH_DIAG_DEF       8'h00
`define MRLH_CNT_ZERO       8'h00
`endif

// [hdl/mrlh_pkg.sv]
// types for the mode, reset and limp home controller
// assumes the map header is on the include path
package mrlh_pkg;
`include "mrlh_map.svh"
   // operating modes of the device
   typedef enum logic [1:0] {
      MRLH_SLEEP,
      MRLH_ON,
      MRLH_LIMP
   } mrlh_mode_t;
   // serial commands decoded by the interface logic, one-cycle pulses
   typedef struct packed {
      logic wake;
      logic stb;
      logic rst;
      logic wr;
   } mrlh_cmd_t;
   // supply status levels
   typedef struct packed {
      logic vbb_ok;
      logic vdd_ok;
   } mrlh_sup_t;
endpackage

// [hdl/mrlh_uv_filter.sv]
// battery undervoltage reset qualifier: holds reset while any supply is low
// assumes supply status levels synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module mrlh_uv_filter
   import mrlh_pkg::*;
#(
   parameter int REL_CYC = 4 // cycles of good supply before release
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rstn_in,
   // supply status
   input  wire logic vbb_ok_in,
   input  wire logic vdd_ok_in,
   // reset request to the controller
   output logic      uv_rst_out
);
   logic [7:0] cnt_r;   // good-supply cycle count
   logic       all_ok;  // every supply above threshold
   assign all_ok = vbb_ok_in & vdd_ok_in;
   // ------------------------------------------------
   // reset asserts on the first edge that samples a supply low; releases after REL_CYC
   // ------------------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_r      <= `MRLH_CNT_ZERO;
         uv_rst_out <= 1'b1;
      end else if (!all_ok) begin
         cnt_r      <= `MRLH_CNT_ZERO;
         uv_rst_out <= 1'b1;
      end else if (cnt_r < 8'(REL_CYC)) begin
         cnt_r      <= cnt_r + 8'h01;
         uv_rst_out <= 1'b1;
      end else begin
         uv_rst_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [hdl/mrlh_ctrl.sv]
// mode, reset and limp home controller of an eight channel relay switch
// assumes all inputs are synchronous to clk_in; commands arrive decoded
`timescale 1ns/1ps
`default_nettype none
module mrlh_ctrl
   import mrlh_pkg::*;
#(
   parameter int NCH     = `MRLH_NCH,
   parameter int REL_CYC = (`MRLH_UVR_DLY_NS * `MRLH_CLK_MHZ) / 1000 / 50
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   // supplies and fail-safe pin
   input  wire logic             vbb_ok_in,
   input  wire logic             vdd_ok_in,
   input  wire logic             limp_home_input_in,
   input  wire logic [1:0]       in_pin_in,
   // decoded serial commands and write data
   input  wire mrlh_cmd_t        cmd_in,
   input  wire logic [NCH-1:0]   ctrl_wdata_in,
   input  wire logic [7:0]       diag_set_in,
   input  wire logic             rd_in,
   input  wire logic             ter_clr_in,
   // status and outputs
   output mrlh_mode_t            mode_out,
   output logic [NCH-1:0]        ch_on_out,
   output logic [NCH-1:0]        ctrl_reg_out,
   output logic [7:0]            diag_reg_out,
   output logic                  transmission_error_flag_out,
   output logic                  std_frame_sel_out,
   output logic                  spi_avail_out,
   output logic                  diag_en_out,
   output logic                  limp_status_out
);
   // ------------------------------------------------
   // internal signals
   // ------------------------------------------------
   logic       uv_rst;       // undervoltage reset, held by the filter
   logic       lhi_d_r;      // previous limp home input sample
   logic       lhi_fall;     // end of limp home
   logic       lhi_rise;     // start of limp home
   logic       cmd_ok;       // command accepted
   logic       any_rst;      // any reset source this cycle
   logic       bank_clr;     // clear register banks this cycle
   logic       ch_kill;      // force every channel off this cycle
   mrlh_mode_t mode_nxt;     // next mode
   logic [NCH-1:0] ch_nxt;   // next channel drive
   logic [NCH-1:0] lh_ch;    // channel drive in limp home

   mrlh_uv_filter #(
      .REL_CYC (REL_CYC)
   ) u_uv (
      .clk_in     (clk_in),
      .rstn_in    (rstn_in),
      .vbb_ok_in  (vbb_ok_in),
      .vdd_ok_in  (vdd_ok_in),
      .uv_rst_out (uv_rst)
   );

   // ------------------------------------------------
   // event decode
   // ------------------------------------------------
   assign lhi_rise = limp_home_input_in & ~lhi_d_r;
   assign lhi_fall = ~limp_home_input_in & lhi_d_r;
   // commands need the logic supply and are dropped in limp home
   assign cmd_ok   = vdd_ok_in & (mode_out != MRLH_LIMP)
                   & ~limp_home_input_in;
   assign any_rst  = uv_rst | (cmd_ok & cmd_in.rst) | lhi_rise
                   | lhi_fall;
   assign bank_clr = any_rst | (mode_nxt == MRLH_SLEEP)
                   | limp_home_input_in;

   // ------------------------------------------------
   // next mode: limp home wins over everything but battery loss
   // ------------------------------------------------
   always_comb begin
      mode_nxt = mode_out;
      case (mode_out)
         MRLH_SLEEP: begin
            if (limp_home_input_in && vbb_ok_in)
               mode_nxt = MRLH_LIMP;
            else if (cmd_ok && cmd_in.wake && !uv_rst)
               mode_nxt = MRLH_ON;
         end
         MRLH_ON: begin
            if (limp_home_input_in)
               mode_nxt = MRLH_LIMP;
            else if (cmd_ok && cmd_in.stb)
               mode_nxt = MRLH_SLEEP;
         end
         MRLH_LIMP: begin
            if (!limp_home_input_in)
               mode_nxt = MRLH_SLEEP;
         end
         default: mode_nxt = MRLH_SLEEP;
      endcase
      // battery loss: no limp home, back to sleep with defaults
      if (!vbb_ok_in)
         mode_nxt = MRLH_SLEEP;
   end

   // ------------------------------------------------
   // channel drive: limp home routes pins to the auto channels
   // ------------------------------------------------
   always_comb begin
      lh_ch = `MRLH_CH_OFF;
      lh_ch[`MRLH_LH_CH_A] = in_pin_in[0];
      lh_ch[`MRLH_LH_CH_B] = in_pin_in[1];
   end
   // limp home needs only battery: a held supply reset caused by a missing
   // logic supply must not starve the limp channels, so only limp edges
   // and battery loss switch them off while in limp home
   assign ch_kill = (lhi_rise | lhi_fall | (cmd_ok & cmd_in.rst))
                  | (uv_rst & (mode_nxt != MRLH_LIMP));
   assign ch_nxt = (!vbb_ok_in || ch_kill) ? `MRLH_CH_OFF :
                   (mode_nxt == MRLH_LIMP) ? lh_ch :
                   (mode_nxt == MRLH_ON)   ? ctrl_reg_out :
                   `MRLH_CH_OFF;

   // ------------------------------------------------
   // mode and channel registers
   // ------------------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mode_out  <= MRLH_SLEEP;
         ch_on_out <= `MRLH_CH_OFF;
         lhi_d_r   <= 1'b0;
      end else begin
         mode_out  <= mode_nxt;
         ch_on_out <= ch_nxt;
         lhi_d_r   <= limp_home_input_in;
      end
   end

   // ------------------------------------------------
   // register banks: control and diagnosis
   // ------------------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_reg_out <= `MRLH_CTRL_DEF;
         diag_reg_out <= `MRLH_DIAG_DEF;
      end else if (bank_clr) begin
         ctrl_reg_out <= `MRLH_CTRL_DEF;
         diag_reg_out <= (any_rst) ? `MRLH_DIAG_DEF : diag_set_in;
      end else begin
         if (cmd_ok && cmd_in.wr)
            ctrl_reg_out <= ctrl_wdata_in;
         diag_reg_out <= diag_reg_out | diag_set_in;
      end
   end

   // ------------------------------------------------
   // error flag: set on reset wins over a clear by a read
   // ------------------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in)
         transmission_error_flag_out <= 1'b1;
      else if (any_rst)
         transmission_error_flag_out <= 1'b1;
      else if (ter_clr_in && vdd_ok_in)
         transmission_error_flag_out <= 1'b0;
   end

   // ------------------------------------------------
   // availability and read selection
   // ------------------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         std_frame_sel_out <= 1'b1;
         spi_avail_out     <= 1'b0;
         diag_en_out       <= 1'b0;
         limp_status_out   <= 1'b0;
      end else begin
         std_frame_sel_out <= uv_rst | (rd_in & uv_rst);
         spi_avail_out     <= vdd_ok_in;
         diag_en_out       <= vbb_ok_in & ~limp_home_input_in;
         limp_status_out   <= (mode_nxt == MRLH_LIMP);
      end
   end
endmodule
`default_nettype wire

// [verification/mrlh_host_model.sv]
// host and fail-safe pin model facing the mode controller
// assumes tasks are called just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module mrlh_host_model
   import mrlh_pkg::*;
(
   // clock
   input  wire logic  clk_in,
   // towards the controller
   output var mrlh_cmd_t cmd_out,
   output logic       limp_out,
   output logic [1:0] pin_out
);
   // idle host: no command, fail-safe pin low
   initial begin
      cmd_out  = mrlh_cmd_t'(4'h0);
      limp_out = 1'b0;
      pin_out  = 2'b00;
   end
   // one-cycle decoded command; an idle edge follows so that back to back
   // calls never raise the strobe in the time step that lowered it
   task automatic send(input logic [3:0] c);
      cmd_out = mrlh_cmd_t'(c);
      @(posedge clk_in);
      #1 cmd_out = mrlh_cmd_t'(4'h0);
      @(posedge clk_in);
      #1;
   endtask
endmodule
`default_nettype wire

// [verification/mrlh_ctrl_chk.sv]
// checker for the mode controller, sees its ports only
// assumes bind to mrlh_ctrl after the module
`timescale 1ns/1ps
`default_nettype none
module mrlh_ctrl_chk
   import mrlh_pkg::*;
(
   input wire logic       clk_in,
   input wire logic       rstn_in,
   input wire logic       vbb_ok_in,
   input wire logic       vdd_ok_in,
   input wire logic       limp_home_input_in,
   input wire logic [1:0] in_pin_in,
   input wire mrlh_cmd_t  cmd_in,
   input wire mrlh_mode_t mode_out,
   input wire logic [7:0] ch_on_out,
   input wire logic [7:0] ctrl_reg_out,
   input wire logic [7:0] diag_reg_out,
   input wire logic       transmission_error_flag_out,
   input wire logic       std_frame_sel_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   wire lim = mode_out == MRLH_LIMP;
   wire ok = vbb_ok_in && vdd_ok_in && !limp_home_input_in;
   // ----------------------------------------
   // mode sequencing
   // ----------------------------------------
   AST_WAKE: assert property (cmd_in.wake && ok && !std_frame_sel_out
      && mode_out == MRLH_SLEEP |=> mode_out == MRLH_ON) else $error("wake lost");
   AST_STB: assert property (cmd_in.stb && !cmd_in.wake && ok && mode_out == MRLH_ON
      |=> mode_out == MRLH_SLEEP && ctrl_reg_out == 8'h00) else $error("sleep bad");
   AST_RSTC: assert property (cmd_in.rst && ok && mode_out == MRLH_ON |=>
      ctrl_reg_out == 8'h00 && diag_reg_out == 8'h00 && transmission_error_flag_out)
      else $error("reset cmd bad");
   AST_LENT: assert property ($rose(limp_home_input_in) && vbb_ok_in |=> lim
      && transmission_error_flag_out && ch_on_out == 8'h00) else $error("no limp");
   AST_LEXIT: assert property ($fell(limp_home_input_in) && lim |=>
      mode_out == MRLH_SLEEP && ch_on_out == 8'h00 && transmission_error_flag_out)
      else $error("limp exit bad");
   AST_LCH: assert property (lim && $past(mode_out) == MRLH_LIMP |->
      ch_on_out == {2'b00, $past(in_pin_in), 4'h0}) else $error("limp drive bad");
   AST_LREG: assert property (lim |-> ctrl_reg_out == 8'h00) else $error("reg kept");
   AST_LIGN: assert property (lim && limp_home_input_in |=> lim)
      else $error("limp left");
   AST_UV: assert property ($fell(vbb_ok_in) ##1 !vbb_ok_in |-> ##[0:2]
      (std_frame_sel_out && ch_on_out == 8'h00 && transmission_error_flag_out))
      else $error("uv late");
   AST_UVH: assert property (!vbb_ok_in && std_frame_sel_out |=> std_frame_sel_out)
      else $error("uv released");
   C_WAKE: cover property (mode_out == MRLH_SLEEP ##1 mode_out == MRLH_ON);
   C_LIMP: cover property (lim ##1 mode_out == MRLH_SLEEP);
   C_UV: cover property ($fell(vbb_ok_in));
endmodule
bind mrlh_ctrl mrlh_ctrl_chk mrlh_ctrl_chk_i (.*);
`default_nettype wire

// [verification/mrlh_ctrl_tb_top.sv]
// self-checking bench for the mode, reset and limp home controller
// assumes the host model drives commands and the fail-safe pin
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module mrlh_ctrl_tb_top;
   import mrlh_pkg::*;
   logic clk_in, rstn_in, vbb, vdd, rd, tclr;
   logic [7:0] wd, ds, ch, cr, dr;
   mrlh_mode_t md;
   mrlh_cmd_t cmd;
   logic lh, fl, sel, sav, den, lst;
   logic [1:0] pin;
   int num_errors = 0, n_tests = 0;
   mrlh_host_model mrlh_host_model_i (.clk_in(clk_in), .cmd_out(cmd), .limp_out(lh),
      .pin_out(pin));
   // release delay cut to one cycle to keep the run short
   mrlh_ctrl #(.REL_CYC(1)) mrlh_ctrl_i (.clk_in(clk_in), .rstn_in(rstn_in),
      .vbb_ok_in(vbb), .vdd_ok_in(vdd), .limp_home_input_in(lh), .in_pin_in(pin),
      .cmd_in(cmd), .ctrl_wdata_in(wd), .diag_set_in(ds), .rd_in(rd), .ter_clr_in(tclr),
      .mode_out(md), .ch_on_out(ch), .ctrl_reg_out(cr), .diag_reg_out(dr),
      .transmission_error_flag_out(fl), .std_frame_sel_out(sel), .spi_avail_out(sav),
      .diag_en_out(den), .limp_status_out(lst));
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic stp(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // wait, bounded, for the undervoltage hold to lift
   task automatic up();
      for (int i = 0; i < 20 && sel !== 1'b0; i++) stp(1);
      `CHK("sel", 1'b0, sel)
   endtask
   task automatic t_mode();
      mrlh_host_model_i.send(4'h8);
      `CHK("mode", MRLH_ON, md)
      wd = 8'hA5;
      mrlh_host_model_i.send(4'h1);
      stp(1);
      `CHK("ch", 8'hA5, ch)
      mrlh_host_model_i.send(4'h4);
      `CHK("sleep", MRLH_SLEEP, md)
      `CHK("ctrl", 8'h00, cr)
      $display("mode test done");
   endtask
   task automatic t_rst();
      mrlh_host_model_i.send(4'h8);
      tclr = 1'b1; ds = 8'h81;
      stp(1);
      tclr = 1'b0; ds = 8'h00;
      stp(1);
      `CHK("flag", 1'b0, fl)
      `CHK("diag", 8'h81, dr)
      mrlh_host_model_i.send(4'h2);
      `CHK("diag", 8'h00, dr)
      `CHK("flag", 1'b1, fl)
      $display("reset test done");
   endtask
   task automatic t_limp();
      mrlh_host_model_i.send(4'h1);
      mrlh_host_model_i.pin_out = 2'b01;
      mrlh_host_model_i.limp_out = 1'b1;
      stp(1);
      `CHK("mode", MRLH_LIMP, md)
      stp(1);
      `CHK("ch", 8'h10, ch)
      mrlh_host_model_i.pin_out = 2'b10;
      mrlh_host_model_i.send(4'h1);
      mrlh_host_model_i.send(4'h8);
      stp(1);
      `CHK("ch", 8'h20, ch)
      `CHK("ctrl", 8'h00, cr)
      mrlh_host_model_i.limp_out = 1'b0;
      stp(1);
      `CHK("mode", MRLH_SLEEP, md)
      `CHK("ch", 8'h00, ch)
      $display("limp test done");
   endtask
   task automatic t_uv();
      mrlh_host_model_i.send(4'h8);
      vbb = 1'b0;
      stp(3);
      `CHK("sel", 1'b1, sel)
      `CHK("mode", MRLH_SLEEP, md)
      rd = 1'b1;
      stp(1);
      rd = 1'b0;
      `CHK("flag", 1'b1, fl)
      vbb = 1'b1;
      up();
      `CHK("ctrl", 8'h00, cr)
      $display("undervoltage test done");
   endtask
   // logic supply lost: commands refused, limp home still drives channels
   task automatic t_vdd();
      vdd = 1'b0;
      stp(2);
      `CHK("spi", 1'b0, sav)
      mrlh_host_model_i.send(4'h8);
      `CHK("mode", MRLH_SLEEP, md)
      mrlh_host_model_i.pin_out = 2'b10;
      mrlh_host_model_i.limp_out = 1'b1;
      stp(3);
      `CHK("mode", MRLH_LIMP, md)
      `CHK("ch", 8'h20, ch)
      `CHK("lst", 1'b1, lst)
      `CHK("den", 1'b0, den)
      mrlh_host_model_i.limp_out = 1'b0;
      stp(1);
      `CHK("mode", MRLH_SLEEP, md)
      vdd = 1'b1;
      up();
      `CHK("spi", 1'b1, sav)
      `CHK("den", 1'b1, den)
      `CHK("lst", 1'b0, lst)
      $display("logic supply test done");
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      rstn_in = 1'b0; vbb = 1'b1; vdd = 1'b1; rd = 1'b0; tclr = 1'b0;
      wd = 8'h00; ds = 8'h00;
      stp(5);
      rstn_in = 1'b1;
      up();
      t_mode();
      t_rst();
      t_limp();
      t_uv();
      t_vdd();
      test_done();
   end
   // watchdog well beyond the few dozen cycles the tests need
   initial begin
      #20000;
      num_errors++;
      test_done();
   end
endmodule
`default_nettype wire
